// file: include/rx_port_stats_regs.svh
// register offsets, field positions, reset values and timing counts of the receive port
`ifndef RX_PORT_STATS_REGS_SVH
`define RX_PORT_STATS_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define VC_REMAP_ADDR          8'h72
`define FRAME_LINES_UPPER_ADDR 8'h73
`define FRAME_LINES_LOWER_ADDR 8'h74
`define LINE_WIDTH_UPPER_ADDR  8'h75
`define LINE_WIDTH_LOWER_ADDR  8'h76
`define RATE_MON_CFG_ADDR      8'h77

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define VC_REMAP_RST           8'hE4
`define RATE_MON_CFG_RST       8'hC5
`define STATS_RST              16'h0000

// ----------------------------------------------------------------------
// field positions of the rate monitor configuration
// ----------------------------------------------------------------------
`define RATE_HYST_MSB          7
`define RATE_HYST_LSB          6
`define RATE_SETTLE_MSB        5
`define RATE_SETTLE_LSB        4
`define RATE_FLOOR_MSB         3
`define RATE_FLOOR_LSB         0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS          10
`define RATE_WINDOW_NS         1000
`define SETTLE_TIME0_US        40
`define SETTLE_TIME1_US        80
`define SETTLE_TIME2_US        320
`define SETTLE_TIME3_US        1280

`endif

// file: include/rx_port_stats_pkg.sv
// types shared by the receive port logic
package rx_port_stats_pkg;

   // input mode of the port, in the order of its two-bit code
   typedef enum logic [1:0] {
      MODE_CSI,
      MODE_RAW12_LOW,
      MODE_RAW12_HIGH,
      MODE_RAW10
   } port_mode_e;

   typedef logic [1:0] vc_t;

endpackage

// file: src/pkt_buffer2.sv
// two-entry buffer with valid and ready on both sides, all outputs registered
`timescale 1ns/100ps
`default_nettype none

module pkt_buffer2 #(
   parameter int W = 10
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         in_valid,
   output var  logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output var  logic         out_valid,
   input  wire logic         out_ready,
   output var  logic [W-1:0] out_data
);

   logic [W-1:0] spare_r;
   logic [1:0]   fill_r;
   logic [1:0]   fill_nxt;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;

   // ----------------------------------------------------------------------
   // occupancy
   // ----------------------------------------------------------------------
   // ready is decided from the next fill so a stalled receiver never loses a word
   assign fill_nxt = fill_r + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fill_r    <= 2'h0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         fill_r    <= fill_nxt;
         in_ready  <= (fill_nxt != 2'h2);
         out_valid <= (fill_nxt != 2'h0);
      end
   end

   // head and spare entries; the head always holds the oldest word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_data <= '0;
         spare_r  <= '0;
      end else if (fill_r == 2'h2) begin
         if (pop) out_data <= spare_r;
      end else if (push) begin
         if (fill_r == 2'h0 || pop) out_data <= in_data;
         else                       spare_r  <= in_data;
      end
   end

endmodule

`default_nettype wire

// file: src/rx_port_vc_remap_video_stats.sv
// receive port: channel remap, frame line statistics and recovered clock rate monitor
//
// Overview of operation
// - each packet accepted in the CSI mode leaves with the two-bit channel picked from the remap byte by its incoming channel.
// - the remap byte comes out of reset as the identity map.
// - the remap is used only in the CSI input mode; the raw modes take the raw-mode channel input.
// - the line count of the last frame reads as two bytes, both zero after reset.
// - with the line count change enable set, a captured count holds until its upper byte is read.
// - reading the count upper byte latches the lower byte for the next lower-byte read.
// - the reported line width of a frame is the length of that frame's final line.
// - with the width change enable set, a captured width holds until its upper byte is read.
// - reading the width upper byte latches the lower byte for the next lower-byte read.
// - a new rate is taken only when it differs from the held rate by more than the hysteresis.
// - the rate is stable once it stays inside the band for the selected settle time.
// - the clock is flagged slow while the held rate is below the floor setting.
`include "rx_port_stats_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module rx_port_vc_remap_video_stats #(
   parameter int DW = 32,
   parameter int LW = 16
) (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic [7:0]    reg_addr,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [7:0]    reg_wdata,
   output var  logic [7:0]    reg_rdata,
   input  wire logic [1:0]    port_mode,
   input  wire logic [1:0]    raw_vc,
   input  wire logic          lines_changed_irq_en,
   input  wire logic          width_changed_irq_en,
   input  wire logic          pkt_in_valid,
   output var  logic          pkt_in_ready,
   input  wire logic [1:0]    pkt_in_vc,
   input  wire logic [DW-1:0] pkt_in_data,
   output var  logic          pkt_out_valid,
   input  wire logic          pkt_out_ready,
   output var  logic [1:0]    pkt_out_vc,
   output var  logic [DW-1:0] pkt_out_data,
   input  wire logic          pix_valid,
   input  wire logic          line_end,
   input  wire logic          frame_end,
   input  wire logic          rx_clk_in,
   output var  logic [7:0]    rate_mhz,
   output var  logic          rate_stable,
   output var  logic          rate_low
);

   localparam int WIN_CYC = `RATE_WINDOW_NS / `CLK_PERIOD_NS;
   localparam int US_CYC  = 1000 / `CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction

   function automatic logic [10:0] settle_us(input logic [1:0] sel);
      case (sel)
         2'h0:    settle_us = 11'(`SETTLE_TIME0_US);
         2'h1:    settle_us = 11'(`SETTLE_TIME1_US);
         2'h2:    settle_us = 11'(`SETTLE_TIME2_US);
         default: settle_us = 11'(`SETTLE_TIME3_US);
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------
   logic [7:0]    vc_remap_r;
   logic [7:0]    rate_cfg_r;
   logic [LW-1:0] lines_rep_r;
   logic [LW-1:0] width_rep_r;
   logic [7:0]    lines_lo_shadow_r;
   logic [7:0]    width_lo_shadow_r;
   logic [7:0]    rd_mux;

   wire wr_remap = reg_wr && (reg_addr == `VC_REMAP_ADDR);
   wire wr_cfg   = reg_wr && (reg_addr == `RATE_MON_CFG_ADDR);
   wire rd_lines = reg_rd && (reg_addr == `FRAME_LINES_UPPER_ADDR);
   wire rd_width = reg_rd && (reg_addr == `LINE_WIDTH_UPPER_ADDR);

   wire [1:0] cfg_hyst   = rate_cfg_r[`RATE_HYST_MSB:`RATE_HYST_LSB];
   wire [1:0] cfg_settle = rate_cfg_r[`RATE_SETTLE_MSB:`RATE_SETTLE_LSB];
   wire [3:0] cfg_floor  = rate_cfg_r[`RATE_FLOOR_MSB:`RATE_FLOOR_LSB];

   // read selection; the lower bytes come from the shadows loaded by the upper reads
   always_comb begin
      case (reg_addr)
         `VC_REMAP_ADDR:          rd_mux = vc_remap_r;
         `FRAME_LINES_UPPER_ADDR: rd_mux = lines_rep_r[15:8];
         `FRAME_LINES_LOWER_ADDR: rd_mux = lines_lo_shadow_r;
         `LINE_WIDTH_UPPER_ADDR:  rd_mux = width_rep_r[15:8];
         `LINE_WIDTH_LOWER_ADDR:  rd_mux = width_lo_shadow_r;
         `RATE_MON_CFG_ADDR:      rd_mux = rate_cfg_r;
         default:                 rd_mux = 8'h00;
      endcase
   end

   // writable bytes and the read data register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vc_remap_r <= `VC_REMAP_RST;
         rate_cfg_r <= `RATE_MON_CFG_RST;
         reg_rdata  <= 8'h00;
      end else begin
         if (wr_remap) vc_remap_r <= reg_wdata;
         if (wr_cfg)   rate_cfg_r <= reg_wdata;
         if (reg_rd)   reg_rdata  <= rd_mux;
      end
   end

   // lower-byte shadows, loaded on an upper-byte read so a pair reads coherently
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lines_lo_shadow_r <= 8'h00;
         width_lo_shadow_r <= 8'h00;
      end else begin
         if (rd_lines) lines_lo_shadow_r <= lines_rep_r[7:0];
         if (rd_width) width_lo_shadow_r <= width_rep_r[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // channel remap into the packet buffer
   // ----------------------------------------------------------------------
   rx_port_stats_pkg::vc_t mapped_vc;
   wire                    csi_mode = (port_mode == rx_port_stats_pkg::MODE_CSI);

   // raw modes bypass the remap byte entirely
   assign mapped_vc = csi_mode ? vc_remap_r[2*pkt_in_vc +: 2] : raw_vc;

   pkt_buffer2 #(
      .W (DW + 2)
   ) u_buf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (pkt_in_valid),
      .in_ready  (pkt_in_ready),
      .in_data   ({mapped_vc, pkt_in_data}),
      .out_valid (pkt_out_valid),
      .out_ready (pkt_out_ready),
      .out_data  ({pkt_out_vc, pkt_out_data})
   );

   // ----------------------------------------------------------------------
   // frame statistics
   // ----------------------------------------------------------------------
   logic [LW-1:0] cur_len_r;
   logic [LW-1:0] last_len_r;
   logic [LW-1:0] cur_lines_r;
   logic          lines_hold_r;
   logic          width_hold_r;

   wire [LW-1:0] len_now    = cur_len_r + LW'(pix_valid);
   wire [LW-1:0] lines_now  = cur_lines_r + LW'(line_end);
   wire [LW-1:0] final_len  = line_end ? len_now : last_len_r;
   wire          lines_frz  = lines_changed_irq_en && lines_hold_r;
   wire          width_frz  = width_changed_irq_en && width_hold_r;
   wire          cap_lines  = frame_end && !lines_frz;
   wire          cap_width  = frame_end && !width_frz;

   // running counters; counts wrap silently beyond the field width
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cur_len_r   <= `STATS_RST;
         last_len_r  <= `STATS_RST;
         cur_lines_r <= `STATS_RST;
      end else begin
         cur_len_r   <= line_end ? `STATS_RST : len_now;
         if (line_end) last_len_r <= len_now;
         cur_lines_r <= frame_end ? `STATS_RST : lines_now;
      end
   end

   // reported values, frozen while an enable is set and the value is unread
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lines_rep_r <= `STATS_RST;
         width_rep_r <= `STATS_RST;
      end else begin
         if (cap_lines) lines_rep_r <= lines_now;
         if (cap_width) width_rep_r <= final_len;
      end
   end

   // hold flags: a fresh capture wins over a read in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lines_hold_r <= 1'b0;
         width_hold_r <= 1'b0;
      end else begin
         if (cap_lines)     lines_hold_r <= 1'b1;
         else if (rd_lines) lines_hold_r <= 1'b0;
         if (cap_width)     width_hold_r <= 1'b1;
         else if (rd_width) width_hold_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // recovered clock rate monitor
   // ----------------------------------------------------------------------
   // the recovered clock is sampled as a pin, so only rates well under
   // half of clk (about 50 MHz) are measured faithfully
   logic       rck_s1_r;
   logic       rck_s2_r;
   logic       rck_s3_r;
   logic [7:0] win_cnt_r;
   logic [7:0] edge_cnt_r;
   logic [10:0] us_cnt_r;
   logic       meas_done_r;
   logic [7:0] meas_r;

   wire       rck_rise  = rck_s2_r && !rck_s3_r;
   wire       win_end   = (win_cnt_r == 8'(WIN_CYC - 1));
   wire [7:0] edges_now = (edge_cnt_r == 8'hFF) ? 8'hFF : edge_cnt_r + 8'(rck_rise);
   wire       rate_jump = abs_diff(meas_r, rate_mhz) > {6'h00, cfg_hyst};
   wire [10:0] settle_lim = settle_us(cfg_settle);

   // two-flop synchroniser, then an edge detector on the settled copy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rck_s1_r <= 1'b0;
         rck_s2_r <= 1'b0;
         rck_s3_r <= 1'b0;
      end else begin
         rck_s1_r <= rx_clk_in;
         rck_s2_r <= rck_s1_r;
         rck_s3_r <= rck_s2_r;
      end
   end

   // rising edges counted over a one microsecond window give MHz directly
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         win_cnt_r   <= 8'h00;
         edge_cnt_r  <= 8'h00;
         meas_r      <= 8'h00;
         meas_done_r <= 1'b0;
      end else begin
         meas_done_r <= win_end;
         win_cnt_r   <= win_end ? 8'h00 : win_cnt_r + 8'h01;
         edge_cnt_r  <= win_end ? 8'h00 : edges_now;
         if (win_end) meas_r <= edges_now;
      end
   end

   // held rate, settle timer and the flags derived from them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rate_mhz    <= 8'h00;
         us_cnt_r    <= 11'h000;
         rate_stable <= 1'b0;
         rate_low    <= 1'b0;
      end else begin
         if (meas_done_r) begin
            if (rate_jump) begin
               rate_mhz    <= meas_r;
               us_cnt_r    <= 11'h000;
               rate_stable <= 1'b0;
            end else begin
               if (us_cnt_r != 11'h7FF) us_cnt_r <= us_cnt_r + 11'h001;
               rate_stable <= (us_cnt_r + 11'h001 >= settle_lim);
            end
         end
         rate_low <= (rate_mhz < {4'h0, cfg_floor});
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_remap;
      @(posedge clk) disable iff (!rstn)
      (!pkt_out_valid && pkt_in_valid && pkt_in_ready && csi_mode)
      |=> (pkt_out_valid && pkt_out_vc == $past(vc_remap_r[2*pkt_in_vc +: 2]));
   endproperty
   a_remap: assert property (p_remap) else $error("remapped channel wrong");

   property p_remap_rst;
      @(posedge clk) $rose(rstn) |-> (vc_remap_r == 8'hE4);
   endproperty
   a_remap_rst: assert property (p_remap_rst) else $error("remap reset wrong");

   property p_raw;
      @(posedge clk) disable iff (!rstn)
      (!pkt_out_valid && pkt_in_valid && pkt_in_ready && !csi_mode)
      |=> (pkt_out_vc == $past(raw_vc));
   endproperty
   a_raw: assert property (p_raw) else $error("raw mode channel wrong");

   property p_stats_rst;
      @(posedge clk) $rose(rstn) |-> (lines_rep_r == 16'h0000 && width_rep_r == 16'h0000);
   endproperty
   a_stats_rst: assert property (p_stats_rst) else $error("stats not zero");

   property p_lines_frz;
      @(posedge clk) disable iff (!rstn)
      (lines_changed_irq_en && lines_hold_r && !rd_lines) |=> $stable(lines_rep_r);
   endproperty
   a_lines_frz: assert property (p_lines_frz) else $error("line count moved while frozen");

   property p_lines_pair;
      @(posedge clk) disable iff (!rstn)
      rd_lines |=> (lines_lo_shadow_r == $past(lines_rep_r[7:0]));
   endproperty
   a_lines_pair: assert property (p_lines_pair) else $error("count low byte not latched");

   property p_width_last;
      @(posedge clk) disable iff (!rstn)
      (frame_end && line_end && !width_frz) |=> (width_rep_r == $past(len_now));
   endproperty
   a_width_last: assert property (p_width_last) else $error("width not final line");

   property p_width_frz;
      @(posedge clk) disable iff (!rstn)
      (width_changed_irq_en && width_hold_r && !rd_width) |=> $stable(width_rep_r);
   endproperty
   a_width_frz: assert property (p_width_frz) else $error("width moved while frozen");

   property p_width_pair;
      @(posedge clk) disable iff (!rstn)
      (rd_width ##1 !reg_rd ##1 (reg_rd && reg_addr == 8'h76))
      |=> (reg_rdata == $past(width_rep_r[7:0], 3));
   endproperty
   a_width_pair: assert property (p_width_pair) else $error("width pair incoherent");

   property p_hyst;
      @(posedge clk) disable iff (!rstn)
      (meas_done_r && !rate_jump) |=> $stable(rate_mhz);
   endproperty
   a_hyst: assert property (p_hyst) else $error("rate moved inside band");

   property p_settle;
      @(posedge clk) disable iff (!rstn)
      rate_stable |-> (us_cnt_r >= settle_lim);
   endproperty
   a_settle: assert property (p_settle) else $error("stable too early");

   property p_floor;
      @(posedge clk) disable iff (!rstn)
      $past(rstn) |-> (rate_low == ($past(rate_mhz) < {4'h0, $past(cfg_floor)}));
   endproperty
   a_floor: assert property (p_floor) else $error("slow flag wrong");

   property p_capture;
      @(posedge clk) disable iff (!rstn)
      (frame_end && !lines_frz) |=> (lines_rep_r == $past(lines_now));
   endproperty
   a_capture: assert property (p_capture) else $error("line count not captured");

endmodule

`default_nettype wire

// file: tb/ser_model.sv
// partner model: remote serializer sending packet words, video strobes and a recovered clock
`timescale 1ns/100ps
`default_nettype none

module ser_model (
   input  wire logic        clk,
   input  wire logic        pkt_in_ready,
   output var  logic        pkt_in_valid,
   output var  logic [1:0]  pkt_in_vc,
   output var  logic [31:0] pkt_in_data,
   output var  logic        pix_valid,
   output var  logic        line_end,
   output var  logic        frame_end,
   output var  logic        rx_clk_in
);
   int half_ns = 0;

   // ----------------------------------------------------------------------
   // idle levels and recovered clock
   // ----------------------------------------------------------------------
   // clock stands low while stopped, so a dead link reads as zero rate
   initial begin
      pkt_in_valid = 1'b0;
      pkt_in_vc    = 2'h0;
      pkt_in_data  = 32'h0000_0000;
      pix_valid    = 1'b0;
      line_end     = 1'b0;
      frame_end    = 1'b0;
      rx_clk_in    = 1'b0;
      forever begin
         if (half_ns == 0) begin
            rx_clk_in = 1'b0;
            #10;
         end else begin
            #(half_ns) rx_clk_in = ~rx_clk_in;
         end
      end
   end

   // ----------------------------------------------------------------------
   // packet words, held until the buffer takes them
   // ----------------------------------------------------------------------
   // a released word shows inverted lines, never the stale word
   task automatic send_words(input int n, input logic [1:0] vc0);
      int i;
      @(posedge clk);
      for (i = 0; i < n; i++) begin
         pkt_in_valid <= 1'b1;
         pkt_in_vc    <= vc0 + i[1:0];
         pkt_in_data  <= 32'hA5A5_0000 + i;
         @(posedge clk);
         while (pkt_in_ready !== 1'b1) @(posedge clk);
      end
      pkt_in_valid <= 1'b0;
      pkt_in_vc    <= ~pkt_in_vc;
      pkt_in_data  <= ~pkt_in_data;
   endtask

   // frame of one-unit lines closed by a longer final line
   task automatic send_frame(input int nlines, input int last_len);
      int l;
      int p;
      int len;
      for (l = 0; l < nlines; l++) begin
         len = (l == nlines - 1) ? last_len : 1;
         for (p = 0; p < len; p++) begin
            @(posedge clk);
            pix_valid <= 1'b1;
            line_end  <= (p == len - 1);
            frame_end <= (l == nlines - 1) && (p == len - 1);
         end
      end
      @(posedge clk);
      pix_valid <= 1'b0;
      line_end  <= 1'b0;
      frame_end <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking testbench of the receive port remap, statistics and rate monitor
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic [1:0]  port_mode = 2'h0;
   logic [1:0]  raw_vc = 2'h0;
   logic        lines_en = 1'b0;
   logic        width_en = 1'b0;
   logic        pkt_in_valid, pkt_in_ready, pkt_out_valid, pix_valid, line_end, frame_end;
   logic        pkt_out_ready = 1'b1;
   logic [1:0]  pkt_in_vc, pkt_out_vc;
   logic [31:0] pkt_in_data, pkt_out_data;
   logic        rx_clk_in, rate_stable, rate_low;
   logic [7:0]  rate_mhz;
   logic [33:0] got_q[$];
   logic [33:0] exp_q[$];
   int          n_errors = 0;
   int          check_count = 0;

   rx_port_vc_remap_video_stats #(.DW(32), .LW(16)) rx_port_vc_remap_video_stats_i (
      .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_mode(port_mode), .raw_vc(raw_vc),
      .lines_changed_irq_en(lines_en), .width_changed_irq_en(width_en),
      .pkt_in_valid(pkt_in_valid), .pkt_in_ready(pkt_in_ready), .pkt_in_vc(pkt_in_vc),
      .pkt_in_data(pkt_in_data), .pkt_out_valid(pkt_out_valid), .pkt_out_ready(pkt_out_ready),
      .pkt_out_vc(pkt_out_vc), .pkt_out_data(pkt_out_data), .pix_valid(pix_valid),
      .line_end(line_end), .frame_end(frame_end), .rx_clk_in(rx_clk_in), .rate_mhz(rate_mhz),
      .rate_stable(rate_stable), .rate_low(rate_low));

   ser_model ser_model_i (
      .clk(clk), .pkt_in_ready(pkt_in_ready), .pkt_in_valid(pkt_in_valid),
      .pkt_in_vc(pkt_in_vc), .pkt_in_data(pkt_in_data), .pix_valid(pix_valid),
      .line_end(line_end), .frame_end(frame_end), .rx_clk_in(rx_clk_in));

   // ----------------------------------------------------------------------
   // clock, output word monitor, watchdog
   // ----------------------------------------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (pkt_out_valid === 1'b1 && pkt_out_ready === 1'b1) got_q.push_back({pkt_out_vc, pkt_out_data});
   end

   // whole run is about 15k cycles; four times that means a hang
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // read data is registered on the strobe edge, sampled just after it
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk($sformatf("reg %h", a), {24'h0, exp}, {24'h0, reg_rdata});
   endtask

   task automatic drain_check();
      repeat (10) @(posedge clk);
      chk("word count", exp_q.size(), got_q.size());
      while (exp_q.size() > 0 && got_q.size() > 0) chk("word", exp_q.pop_front(), got_q.pop_front());
      exp_q.delete();
      got_q.delete();
   endtask

   task automatic end_of_test();
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      chk("rate_low", 1, rate_low);
      rd(8'h72, 8'hE4);
      wr(8'h73, 8'hFF);
      rd(8'h73, 8'h00);
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h00);
      rd(8'h77, 8'hC5);
      rd(8'h78, 8'h00);
   endtask

   // identity map, then a reversed map while the receiver stalls
   task automatic t_remap();
      int i;
      ser_model_i.send_words(4, 2'h0);
      for (i = 0; i < 4; i++) exp_q.push_back({i[1:0], 32'hA5A5_0000 + i});
      drain_check();
      wr(8'h72, 8'h1B);
      pkt_out_ready <= 1'b0;
      fork
         ser_model_i.send_words(4, 2'h0);
         begin
            repeat (8) @(posedge clk);
            #1 chk("in_ready full", 0, pkt_in_ready);
            @(posedge clk);
            pkt_out_ready <= 1'b1;
         end
      join
      for (i = 0; i < 4; i++) exp_q.push_back({2'h3 - i[1:0], 32'hA5A5_0000 + i});
      drain_check();
   endtask

   // raw modes ignore the remap byte
   task automatic t_raw();
      int m;
      for (m = 1; m < 4; m++) begin
         @(posedge clk);
         port_mode <= m[1:0];
         raw_vc    <= 2'h3 - m[1:0];
         ser_model_i.send_words(1, 2'h0);
         exp_q.push_back({2'h3 - m[1:0], 32'hA5A5_0000});
         drain_check();
      end
      @(posedge clk);
      port_mode <= 2'h0;
   endtask

   task automatic t_stats();
      ser_model_i.send_frame(257, 258);
      rd(8'h73, 8'h01);
      rd(8'h75, 8'h01);
      ser_model_i.send_frame(3, 5);
      rd(8'h74, 8'h01);
      rd(8'h76, 8'h02);
      rd(8'h73, 8'h00);
      rd(8'h74, 8'h03);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h05);
   endtask

   task automatic t_freeze();
      @(posedge clk);
      lines_en <= 1'b1;
      width_en <= 1'b1;
      ser_model_i.send_frame(2, 6);
      ser_model_i.send_frame(4, 9);
      rd(8'h73, 8'h00);
      rd(8'h74, 8'h02);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h06);
      ser_model_i.send_frame(5, 3);
      rd(8'h73, 8'h00);
      rd(8'h74, 8'h05);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h03);
      @(posedge clk);
      lines_en <= 1'b0;
      width_en <= 1'b0;
   endtask

   // 10 MHz, 12.5 MHz inside the band, 2 MHz below the floor, back with a longer settle;
   // zero hysteresis around the first step and the drop to 2 MHz, else a partial window could stick as the held rate
   task automatic t_rate();
      wr(8'h77, 8'h05);
      ser_model_i.half_ns = 50;
      repeat (400) @(posedge clk);
      #1 chk("rate_mhz", 10, rate_mhz);
      chk("rate_low", 0, rate_low);
      repeat (4500) @(posedge clk);
      #1 chk("rate_stable", 1, rate_stable);
      wr(8'h77, 8'hC5);
      ser_model_i.half_ns = 40;
      repeat (400) @(posedge clk);
      #1 chk("rate_mhz band", 10, rate_mhz);
      wr(8'h77, 8'h05);
      ser_model_i.half_ns = 250;
      repeat (400) @(posedge clk);
      #1 chk("rate_mhz", 2, rate_mhz);
      chk("rate_low", 1, rate_low);
      chk("rate_stable", 0, rate_stable);
      wr(8'h77, 8'hD5);
      ser_model_i.half_ns = 50;
      repeat (5000) @(posedge clk);
      #1 chk("rate_stable 80us", 0, rate_stable);
      repeat (4000) @(posedge clk);
      #1 chk("rate_stable 80us", 1, rate_stable);
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1 t_reset();
      t_remap();
      t_raw();
      t_stats();
      t_freeze();
      t_rate();
      end_of_test();
   end
endmodule
`default_nettype wire
